// file: logic/pbs_defines.vh
// Purpose: Shared constants for the pipelined burst SRAM port.
// Assumes: Included by bare name from every design file.
// Notes: Byte addresses on the register bus; offsets are word aligned.
`ifndef PBS_DEFINES_VH
`define PBS_DEFINES_VH

// Array shape
`define PBS_AW          17
`define PBS_DW          36
`define PBS_LANES       4
`define PBS_LANE_W      9
`define PBS_WORDS       131072

// Write buffer shape: address, lane enables, data
`define PBS_FIFO_DEPTH  16
`define PBS_FIFO_AW     4
`define PBS_FIFO_W      57

// Pipeline depth from address edge to data edge
`define PBS_PIPE_DEPTH  2

// Register offsets
`define PBS_REG_CTRL    8'h00
`define PBS_REG_STAT    8'h04
`define PBS_REG_BEATS   8'h08

// Field positions
`define PBS_CTRL_PAUSE  0
`define PBS_STAT_EMPTY  0
`define PBS_STAT_FULL   1
`define PBS_STAT_BURST  2
`define PBS_STAT_OVF    3
`define PBS_STAT_LVL    4

// Reset values
`define PBS_CTRL_RST    1'h0
`define PBS_BEATS_RST   16'h0000

`endif

// file: logic/pbs_fifo.v
// Purpose: Synchronous FIFO with valid and ready on both sides.
// Assumes: Single clock, synchronous active-low reset.
// Notes: Read data is shown from the head entry without a cycle of delay.
`timescale 1ns/1ps
`default_nettype none
`include "pbs_defines.vh"

module pbs_fifo #(
	parameter WIDTH = `PBS_FIFO_W,
	parameter DEPTH = `PBS_FIFO_DEPTH,
	parameter AW    = `PBS_FIFO_AW
) (
	// Clock and reset
	input  wire             mclk,
	input  wire             nrst,
	// Fill side
	input  wire             inValid,
	output wire             inReady,
	input  wire [WIDTH-1:0] inData,
	// Drain side
	output wire             outValid,
	input  wire             outReady,
	output wire [WIDTH-1:0] outData,
	// Fill level
	output wire [AW:0]      level
);

	reg [WIDTH-1:0] store [0:DEPTH-1];
	reg [AW-1:0]    wrPtr;
	reg [AW-1:0]    rdPtr;
	reg [AW:0]      count;
	wire            push;
	wire            pop;

	// Full and empty come from the count, so both are exact
	assign inReady  = (count != DEPTH[AW:0]);
	assign outValid = (count != {(AW+1){1'b0}});
	assign outData  = store[rdPtr];
	assign level    = count;
	assign push     = inValid & inReady;
	assign pop      = outValid & outReady;

	// Entry storage has no reset; only pointers and count need a defined value
	always @(posedge mclk)
	begin
		if (push)
			store[wrPtr] <= inData;
	end

	// Pointers and count
	always @(posedge mclk)
	begin
		if (!nrst)
		begin
			wrPtr <= {AW{1'b0}};
			rdPtr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wrPtr <= wrPtr + 1'b1;
			if (pop)
				rdPtr <= rdPtr + 1'b1;
			if (push && !pop)
				count <= count + 1'b1;
			else if (pop && !push)
				count <= count - 1'b1;
		end
	end

endmodule
`default_nettype wire

// file: logic/pbs_sram_port.v
// Purpose: Synchronous pipelined burst SRAM with a Wishbone status port.
// Assumes: Bus pins are driven from logic on mclk; one clock domain.
// Notes: Writes pass a 16-word buffer before reaching the array.
// Function
// - A load strobe sampled low ends any burst and, when selected, captures new address and control.
// - While the strobe is high and a burst runs, the read/write select is ignored.
// - The burst direction is fixed at the load and kept for every following beat.
// - A load with the read/write select low starts a write access.
// - Byte enables come two cycles before their data and are applied to that data.
// - A clock enable sampled high makes the edge absent and the burst, pipeline, buffer and array registers hold.
// - A burst advances only the two lowest address bits, giving four words.
// - The burst order select picks linear or interleaved order.
`timescale 1ns/1ps
`default_nettype none
`include "pbs_defines.vh"

module pbs_sram_port (
	// Clock and reset
	input  wire                    mclk,
	input  wire                    nrst,
	// Synchronous SRAM bus
	input  wire [`PBS_AW-1:0]      address,
	input  wire                    advanceLoadStrobe,
	input  wire                    readWriteSel,
	input  wire                    clockEnableN,
	input  wire                    chipSelectLowAN,
	input  wire                    chipSelectHigh,
	input  wire                    chipSelectLowBN,
	input  wire [`PBS_LANES-1:0]   byteWriteEnablesN,
	input  wire                    burstOrderSelect,
	// Data pins, split into in, out and enable
	input  wire [`PBS_DW-1:0]      dqIn,
	output reg  [`PBS_DW-1:0]      dqOut,
	output reg                     dqOe,
	// Write buffer can accept a beat
	output reg                     writeBufReady,
	// Wishbone slave
	input  wire                    cyc_i,
	input  wire                    stb_i,
	input  wire                    we_i,
	input  wire [7:0]              adr_i,
	input  wire [31:0]             dat_i,
	input  wire [3:0]              sel_i,
	output reg  [31:0]             dat_o,
	output reg                     ack_o
);

	// Memory array
	reg  [`PBS_DW-1:0]    mem [0:`PBS_WORDS-1];

	// Load and burst state
	reg                   burstActive;
	reg                   burstWrite;
	reg  [`PBS_AW-1:0]    baseAddr;
	reg  [1:0]            burstCnt;

	// Pipeline stages one and two
	reg                   s1Valid;
	reg                   s1Write;
	reg  [`PBS_AW-1:0]    s1Addr;
	reg  [`PBS_LANES-1:0] s1Be;
	reg                   s2Valid;
	reg                   s2Write;
	reg  [`PBS_AW-1:0]    s2Addr;
	reg  [`PBS_LANES-1:0] s2Be;

	// Next values for the load stage
	reg                   next_s1Valid;
	reg                   next_s1Write;
	reg  [`PBS_AW-1:0]    next_s1Addr;
	reg                   next_burstActive;
	reg                   next_burstWrite;
	reg  [`PBS_AW-1:0]    next_baseAddr;
	reg  [1:0]            next_burstCnt;
	reg  [1:0]            beatLow;

	// Burst order strap synchroniser
	reg                   orderMeta;
	reg                   orderSync;

	// Software registers
	reg                   commitPause;
	reg                   overflow;
	reg  [15:0]           writeBeats;

	// Write buffer wiring
	wire                  edgeOn;
	wire                  selected;
	wire                  pushBeat;
	wire                  bufInReady;
	wire                  bufOutValid;
	wire                  bufOutReady;
	wire [`PBS_FIFO_W-1:0] bufInData;
	wire [`PBS_FIFO_W-1:0] bufOutData;
	wire [`PBS_FIFO_AW:0] bufLevel;
	wire [`PBS_AW-1:0]    commitAddr;
	wire [`PBS_LANES-1:0] commitBe;
	wire [`PBS_DW-1:0]    commitData;
	wire [`PBS_DW-1:0]    oldWord;
	wire [`PBS_DW-1:0]    mergedWord;
	wire                  commitFire;

	// Bus access decode
	wire                  wbAccess;
	wire                  wbWrite;

	// A high clock enable blocks the edge for the burst, pipeline, buffer and array state
	assign edgeOn   = ~clockEnableN;
	// All three selects must agree; any inactive one deselects
	assign selected = ~chipSelectLowAN & chipSelectHigh & ~chipSelectLowBN;

	// Strap is quasi-static but still passes two flops before use
	always @(posedge mclk)
	begin
		if (!nrst)
		begin
			orderMeta <= 1'b0;
			orderSync <= 1'b0;
		end
		else
		begin
			orderMeta <= burstOrderSelect;
			orderSync <= orderMeta;
		end
	end

	// Low two address bits of the next beat in the chosen order
	always @*
	begin
		if (orderSync)
			beatLow = baseAddr[1:0] ^ (burstCnt + 2'h1);
		else
			beatLow = baseAddr[1:0] + burstCnt + 2'h1;
	end

	// Decide what enters stage one on this edge
	always @*
	begin
		next_s1Valid     = 1'b0;
		next_s1Write     = burstWrite;
		next_s1Addr      = {baseAddr[`PBS_AW-1:2], beatLow};
		next_burstActive = burstActive;
		next_burstWrite  = burstWrite;
		next_baseAddr    = baseAddr;
		next_burstCnt    = burstCnt;
		if (!advanceLoadStrobe)
		begin
			// A load always ends the old burst, selected or not
			next_burstActive = 1'b0;
			if (selected)
			begin
				next_s1Valid     = 1'b1;
				next_s1Write     = ~readWriteSel;
				next_s1Addr      = address;
				next_burstActive = 1'b1;
				next_burstWrite  = ~readWriteSel;
				next_baseAddr    = address;
				next_burstCnt    = 2'h0;
			end
			// Deselected load leaves stages two onward untouched
		end
		else if (burstActive)
		begin
			// Select input is not looked at while bursting
			next_s1Valid  = 1'b1;
			next_s1Write  = burstWrite;
			next_s1Addr   = {baseAddr[`PBS_AW-1:2], beatLow};
			next_burstCnt = burstCnt + 2'h1;
		end
	end

	// Load stage and burst counter
	always @(posedge mclk)
	begin
		if (!nrst)
		begin
			burstActive <= 1'b0;
			burstWrite  <= 1'b0;
			baseAddr    <= {`PBS_AW{1'b0}};
			burstCnt    <= 2'h0;
			s1Valid     <= 1'b0;
			s1Write     <= 1'b0;
			s1Addr      <= {`PBS_AW{1'b0}};
			s1Be        <= {`PBS_LANES{1'b0}};
		end
		else if (edgeOn)
		begin
			burstActive <= next_burstActive;
			burstWrite  <= next_burstWrite;
			baseAddr    <= next_baseAddr;
			burstCnt    <= next_burstCnt;
			s1Valid     <= next_s1Valid;
			s1Write     <= next_s1Write;
			s1Addr      <= next_s1Addr;
			// Lane enables ride with the address edge of their beat
			s1Be        <= ~byteWriteEnablesN;
		end
	end

	// Stage two, read data launch and bus turnaround
	always @(posedge mclk)
	begin
		if (!nrst)
		begin
			s2Valid <= 1'b0;
			s2Write <= 1'b0;
			s2Addr  <= {`PBS_AW{1'b0}};
			s2Be    <= {`PBS_LANES{1'b0}};
			dqOut   <= {`PBS_DW{1'b0}};
			dqOe    <= 1'b0;
		end
		else if (edgeOn)
		begin
			s2Valid <= s1Valid;
			s2Write <= s1Write;
			s2Addr  <= s1Addr;
			s2Be    <= s1Be;
			// Driven after the first edge so it is sampled at the second
			dqOe    <= s1Valid & ~s1Write;
			if (s1Valid && !s1Write)
				dqOut <= mem[s1Addr];
		end
	end

	// Write beat is taken at the second edge with the delayed enables
	assign pushBeat  = edgeOn & s2Valid & s2Write;
	assign bufInData = {s2Addr, s2Be, dqIn};

	// Drain stops while paused or while the edge is blocked
	assign bufOutReady = edgeOn & ~commitPause;

	pbs_fifo #(
		.WIDTH (`PBS_FIFO_W),
		.DEPTH (`PBS_FIFO_DEPTH),
		.AW    (`PBS_FIFO_AW)
	) writeBuf (
		.mclk     (mclk),
		.nrst     (nrst),
		.inValid  (pushBeat),
		.inReady  (bufInReady),
		.inData   (bufInData),
		.outValid (bufOutValid),
		.outReady (bufOutReady),
		.outData  (bufOutData),
		.level    (bufLevel)
	);

	// Unpack the head entry
	assign commitAddr = bufOutData[`PBS_FIFO_W-1:`PBS_DW+`PBS_LANES];
	assign commitBe   = bufOutData[`PBS_DW+`PBS_LANES-1:`PBS_DW];
	assign commitData = bufOutData[`PBS_DW-1:0];
	assign commitFire = bufOutValid & bufOutReady;
	assign oldWord    = mem[commitAddr];

	// Merge per lane so disabled bytes keep their old contents
	genvar lane;
	generate
		for (lane = 0; lane < `PBS_LANES; lane = lane + 1)
		begin : gLane
			assign mergedWord[lane*`PBS_LANE_W +: `PBS_LANE_W] = commitBe[lane]
				? commitData[lane*`PBS_LANE_W +: `PBS_LANE_W]
				: oldWord[lane*`PBS_LANE_W +: `PBS_LANE_W];
		end
	endgenerate

	// Array write port; one buffered beat per enabled cycle
	always @(posedge mclk)
	begin
		if (commitFire)
			mem[commitAddr] <= mergedWord;
	end

	// Ready pin tells the controller to stop issuing writes
	always @(posedge mclk)
	begin
		if (!nrst)
			writeBufReady <= 1'b0;
		else
			writeBufReady <= bufInReady;
	end

	// One-cycle ack, dropped in the cycle after it is given
	assign wbAccess = cyc_i & stb_i & ~ack_o;
	assign wbWrite  = wbAccess & we_i & sel_i[0];

	always @(posedge mclk)
	begin
		if (!nrst)
			ack_o <= 1'b0;
		else
			ack_o <= wbAccess;
	end

	// Control register and beat counter
	always @(posedge mclk)
	begin
		if (!nrst)
		begin
			commitPause <= `PBS_CTRL_RST;
			writeBeats  <= `PBS_BEATS_RST;
		end
		else
		begin
			if (wbWrite && adr_i == `PBS_REG_CTRL)
				commitPause <= dat_i[`PBS_CTRL_PAUSE];
			// Writing the counter clears it; a beat in that cycle still counts
			if (wbWrite && adr_i == `PBS_REG_BEATS)
				writeBeats <= {15'h0000, pushBeat};
			else if (pushBeat)
				writeBeats <= writeBeats + 16'h0001;
		end
	end

	// Overflow is sticky; a lost beat in the clearing cycle wins
	always @(posedge mclk)
	begin
		if (!nrst)
			overflow <= 1'b0;
		else if (pushBeat && !bufInReady)
			overflow <= 1'b1;
		else if (wbWrite && adr_i == `PBS_REG_STAT && dat_i[`PBS_STAT_OVF])
			overflow <= 1'b0;
	end

	// Read data mux; unmapped offsets answer zero
	always @(posedge mclk)
	begin
		if (!nrst)
			dat_o <= 32'h00000000;
		else if (wbAccess)
		begin
			case (adr_i)
				`PBS_REG_CTRL:
					dat_o <= {31'h00000000, commitPause};
				`PBS_REG_STAT:
					dat_o <= {23'h000000, bufLevel, overflow, burstActive,
						~bufInReady, ~bufOutValid};
				`PBS_REG_BEATS:
					dat_o <= {16'h0000, writeBeats};
				default:
					dat_o <= 32'h00000000;
			endcase
		end
	end

endmodule
`default_nettype wire

// file: verif/pbs_chk.sv
// Purpose: Pin timing checks for the burst SRAM port.
// Assumes: One clock, synchronous active-low reset.
// Notes: Only enabled edges count as beats.
`timescale 1ns/1ps
`default_nettype none
module pbs_chk (
	// Clock and reset
	input wire logic        mclk,
	input wire logic        nrst,
	// SRAM bus
	input wire logic        advanceLoadStrobe,
	input wire logic        readWriteSel,
	input wire logic        clockEnableN,
	input wire logic        chipSelectLowAN,
	input wire logic        chipSelectHigh,
	input wire logic        chipSelectLowBN,
	input wire logic [35:0] dqOut,
	input wire logic        dqOe,
	// Wishbone
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        ack_o,
	input wire logic [31:0] dat_o
);
	// Beat decode; a blocked edge is no beat at all
	wire en = !clockEnableN;
	wire sel = !chipSelectLowAN && chipSelectHigh && !chipSelectLowBN;
	wire ld = en && !advanceLoadStrobe;
	wire rdLd = ld && sel && readWriteSel;
	wire wrLd = ld && sel && !readWriteSel;
	wire adv = en && advanceLoadStrobe;
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	a_read_drive: assert property (rdLd ##1 en |=> dqOe)
		else $error("read load not driven");
	a_write_release: assert property (wrLd ##1 en |=> !dqOe)
		else $error("write load drove bus");
	a_rd_burst: assert property (rdLd ##1 adv[*3] |=> dqOe)
		else $error("read burst lost drive");
	a_wr_burst: assert property (wrLd ##1 adv[*3] |=> !dqOe)
		else $error("write burst turned to read");
	a_desel_idle: assert property (ld && !sel ##1 en |=> !dqOe)
		else $error("deselected load drove bus");
	a_freeze_hold: assert property (!en |=> $stable(dqOut) && $stable(dqOe))
		else $error("state moved on blocked edge");
	a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("bus request not acked");
	a_ack_once: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	a_dat_hold: assert property ($changed(dat_o) |-> ack_o)
		else $error("read data moved without ack");
	c_rd_burst: cover property (rdLd ##1 adv[*3]);
	c_wr_burst: cover property (wrLd ##1 adv[*3]);
	c_freeze: cover property (!en && dqOe);
endmodule
bind pbs_sram_port pbs_chk u_chk (.mclk, .nrst, .advanceLoadStrobe, .readWriteSel,
	.clockEnableN, .chipSelectLowAN, .chipSelectHigh, .chipSelectLowBN, .dqOut, .dqOe,
	.cyc_i, .stb_i, .ack_o, .dat_o);
`default_nettype wire

// file: verif/pbs_ctl_model.sv
// Purpose: Memory controller model on the SRAM bus.
// Assumes: The bench issues one beat per clock.
// Notes: Undriven data lines toggle so stale data never matches.
`timescale 1ns/1ps
`default_nettype none
module pbs_ctl_model (
	// Clock
	input  wire logic        mclk,
	// SRAM bus
	output logic [16:0]      address,
	output logic             advanceLoadStrobe,
	output logic             readWriteSel,
	output logic             clockEnableN,
	output logic             chipSelectLowAN,
	output logic             chipSelectHigh,
	output logic             chipSelectLowBN,
	output logic [3:0]       byteWriteEnablesN,
	// Data pins
	input  wire logic [35:0] dqOut,
	input  wire logic        dqOe,
	output logic [35:0]      dqIn
);
	logic [35:0] rdQ[$];
	logic [37:0] pipe0 = 38'h0, pipe1 = 38'h0;
	logic [35:0] nextD = 36'h0, last = 36'h0;
	logic        run = 1'b0, dir = 1'b0;
	wire sel = !chipSelectLowAN && chipSelectHigh && !chipSelectLowBN;
	wire go = advanceLoadStrobe ? run : sel;
	wire rw = advanceLoadStrobe ? dir : readWriteSel;
	// Write data goes out two enabled edges after its enables
	assign dqIn = dqOe ? dqOut : pipe1[36] ? pipe1[35:0] : ~last;
	// Idle bus: deselected load
	initial
	begin
		address = 17'h00000;
		{advanceLoadStrobe, readWriteSel, clockEnableN} = 3'h2;
		{chipSelectLowAN, chipSelectHigh, chipSelectLowBN} = 3'h5;
		byteWriteEnablesN = 4'hf;
	end
	// Beat pipeline; read data taken at the second enabled edge
	always @(posedge mclk)
	begin
		last <= dqIn;
		if (!clockEnableN)
		begin
			if (pipe1[37])
				rdQ.push_back(dqOut);
			pipe1 <= pipe0;
			pipe0 <= {go && rw, go && !rw, nextD};
			if (!advanceLoadStrobe)
			begin
				run <= sel;
				dir <= readWriteSel;
			end
		end
	end
	task beat(input logic ld, r, cs, clock_enable_n, input logic [16:0] a, input logic [3:0] be,
		input logic [35:0] d);
	begin
		@(posedge mclk);
		address <= a;
		advanceLoadStrobe <= !ld;
		readWriteSel <= r;
		clockEnableN <= clock_enable_n;
		{chipSelectLowAN, chipSelectLowBN} <= {!cs, !cs};
		chipSelectHigh <= cs;
		byteWriteEnablesN <= be;
		nextD <= d;
	end
	endtask
endmodule
`default_nettype wire

// file: verif/pbs_sram_port_tb_top.sv
// Purpose: Self-checking bench for the burst SRAM port.
// Assumes: 10 MHz clock; beats come from the controller model.
// Notes: Reads wait for the write buffer to drain first.
`timescale 1ns/1ps
`default_nettype none
module pbs_sram_port_tb_top;
	logic        mclk, nrst, burstOrderSelect, cyc_i, stb_i, we_i;
	logic [7:0]  adr_i;
	logic [31:0] dat_i, q;
	logic [3:0]  sel_i;
	wire  [16:0] address;
	wire         advanceLoadStrobe, readWriteSel, clockEnableN, chipSelectLowAN;
	wire         chipSelectHigh, chipSelectLowBN, dqOe, writeBufReady, ack_o;
	wire  [3:0]  byteWriteEnablesN;
	wire  [35:0] dqIn, dqOut;
	wire  [31:0] dat_o;
	int          errors = 0, checks = 0;
	pbs_ctl_model m (.mclk, .address, .advanceLoadStrobe, .readWriteSel, .clockEnableN,
		.chipSelectLowAN, .chipSelectHigh, .chipSelectLowBN, .byteWriteEnablesN,
		.dqOut, .dqOe, .dqIn);
	pbs_sram_port uut (.mclk, .nrst, .address, .advanceLoadStrobe, .readWriteSel,
		.clockEnableN, .chipSelectLowAN, .chipSelectHigh, .chipSelectLowBN,
		.byteWriteEnablesN, .burstOrderSelect, .dqIn, .dqOut, .dqOe, .writeBufReady,
		.cyc_i, .stb_i, .we_i, .adr_i, .dat_i, .sel_i, .dat_o, .ack_o);
	function logic [35:0] pat(input logic [16:0] a);
		return {2'h1, a, ~a};
	endfunction
	task chk(input logic [35:0] s, e);
	begin
		checks++;
		if (s !== e)
		begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	end
	endtask
	task end_sim;
	begin
		if (errors == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	end
	endtask
	// One classic Wishbone cycle; waits for ack with no fixed latency
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
	begin
		@(posedge mclk);
		{cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'h3, w, a, d, 4'hf};
		do
			@(posedge mclk);
		while (ack_o !== 1'b1);
		q = dat_o;
		{cyc_i, stb_i} <= 2'h0;
	end
	endtask
	task ld(input logic r, input logic [16:0] a, input logic [3:0] be, input logic [35:0] d);
		m.beat(1, r, 1, 0, a, be, d);
	endtask
	task ad(input logic r, input logic [35:0] d);
		m.beat(0, r, 1, 0, 17'h0, 4'h0, d);
	endtask
	task idle(input int n);
		repeat (n) m.beat(1, 1, 0, 0, 17'h0, 4'hf, 36'h0);
	endtask
	task q4(input logic [16:0] a0, a1, a2, a3);
	begin
		// Fourth word lands at the edge the third idle beat is set on; wait one more
		idle(4);
		chk(m.rdQ.pop_front(), pat(a0));
		chk(m.rdQ.pop_front(), pat(a1));
		chk(m.rdQ.pop_front(), pat(a2));
		chk(m.rdQ.pop_front(), pat(a3));
	end
	endtask
	// 100 ns clock
	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	// Watchdog: the whole sequence needs well under 1000 cycles
	initial
	begin
		repeat (3000) @(posedge mclk);
		errors++;
		end_sim;
	end
	initial
	begin
		{nrst, burstOrderSelect, cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} = 49'hf;
		repeat (5) @(posedge mclk);
		nrst <= 1'b1;
		wb(0, 8'h00, 0);
		chk(q, 0);
		// Linear write burst, select flipped to read while advancing
		ld(0, 17'h10, 4'h0, pat(17'h10));
		ad(1, pat(17'h11));
		ad(1, pat(17'h12));
		ad(1, pat(17'h13));
		ld(0, 17'h20, 4'h0, 36'h0);
		ld(0, 17'h20, 4'ha, 36'hfffffffff);
		ld(0, 17'h30, 4'h0, pat(17'h31));
		m.beat(1, 0, 0, 0, 17'h30, 4'h0, pat(17'h30));
		idle(20);
		ld(1, 17'h12, 4'hf, 0);
		repeat (3) ad(0, 0);
		q4(17'h12, 17'h13, 17'h10, 17'h11);
		// Blocked edges inside a read burst
		ld(1, 17'h10, 4'hf, 0);
		m.beat(0, 0, 1, 1, 17'h0, 4'h0, 0);
		ad(0, 0);
		repeat (2) m.beat(0, 0, 1, 1, 17'h0, 4'h0, 0);
		ad(0, 0);
		ad(0, 0);
		q4(17'h10, 17'h11, 17'h12, 17'h13);
		ld(1, 17'h11, 4'hf, 0);
		ad(0, 0);
		ld(1, 17'h20, 4'hf, 0);
		ld(1, 17'h30, 4'hf, 0);
		idle(4);
		chk(m.rdQ.pop_front(), pat(17'h11));
		chk(m.rdQ.pop_front(), pat(17'h12));
		chk(m.rdQ.pop_front(), 36'h007fc01ff);
		chk(m.rdQ.pop_front(), pat(17'h31));
		burstOrderSelect <= 1'b1;
		idle(3);
		ld(1, 17'h11, 4'hf, 0);
		repeat (3) ad(1, 0);
		q4(17'h11, 17'h10, 17'h13, 17'h12);
		// Paused buffer filled past full, then drained
		wb(1, 8'h00, 1);
		for (logic [4:0] i = 0; i < 17; i++)
			ld(0, {12'h0, i} + 17'h40, 4'h0, pat(17'h40));
		idle(3);
		// Ready pin trails the buffer by a cycle, so look after the status read
		wb(0, 8'h04, 0);
		chk(q, 32'h10a);
		chk(writeBufReady, 0);
		wb(1, 8'h04, 8);
		wb(1, 8'h00, 0);
		idle(20);
		wb(0, 8'h04, 0);
		chk(q, 32'h1);
		chk(writeBufReady, 1);
		// Beats: 4 burst, 2 merged, 1 single, 17 paused (one dropped still counts)
		wb(0, 8'h08, 0);
		chk(q, 32'h18);
		wb(1, 8'h08, 0);
		wb(0, 8'h08, 0);
		chk(q, 0);
		wb(0, 8'h0c, 0);
		chk(q, 0);
		end_sim;
	end
endmodule
`default_nettype wire
